// File: eodc_pkg.sv
package eodc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 12;   // Byte address width seen by the slave
  localparam int unsigned DATA_W   = 32;   // APB data width
  localparam int unsigned STRB_W   = 4;    // One strobe per byte lane
  localparam int unsigned CTRL_W   = 24;   // Width of the electrode-off control word
  localparam int unsigned NUM_ELEC = 6;    // LA, LL, RA, V1, V2, CE

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DEVICE_CONTROL       = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ELECTRODE_OFF_CONTROL = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_DETECT_STATUS        = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_NO_OPERATION         = 12'h00c;

  // ----------------------------------------------------------------
  // Device control fields
  // ----------------------------------------------------------------
  localparam int unsigned SOFT_RESET_BIT = 0;  // soft_reset_request
  localparam int unsigned CAL_DAC_BIT    = 1;  // Calibration DAC enable

  // ----------------------------------------------------------------
  // Electrode-off control fields
  // ----------------------------------------------------------------
  localparam int unsigned PHASE_MSB  = 23;  // Per-electrode ac phase
  localparam int unsigned PHASE_LSB  = 18;
  localparam int unsigned ACEN_MSB   = 17;  // Per-electrode ac enables
  localparam int unsigned ACEN_LSB   = 12;
  localparam int unsigned ACCUR_MSB  = 8;   // ac_drive_current_level
  localparam int unsigned ACCUR_LSB  = 7;
  localparam int unsigned DCCUR_MSB  = 4;   // dc_drive_current_level
  localparam int unsigned DCCUR_LSB  = 2;
  localparam int unsigned GLOBAL_AC_DETECT_SELECT_BIT  = 1;   // global_ac_detect_select
  localparam int unsigned ELECTRODE_OFF_DETECT_ENABLE_BIT = 0;   // electrode_off_detect_enable

  // ----------------------------------------------------------------
  // Detect status fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_ACEN_LSB  = 0;  // Effective ac enables [5:0]
  localparam int unsigned STAT_DC_BIT    = 6;  // dc detection active
  localparam int unsigned STAT_PEND_BIT  = 7;  // Soft reset waiting for no-op

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0]   EOC_RESET       = 24'h000000;
  localparam logic [CTRL_W-1:0]   EOC_WRITE_MASK  = 24'hfff19f;  // Reserved 11:9, 6:5 stay 0
  localparam logic [1:0]          DEVCTL_RESET    = 2'h0;
  localparam logic [NUM_ELEC-1:0] GLOBAL_AC_MASK  = 6'h3e;  // CE (index 0) excluded

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EODC_RUN      = 2'b01,   // Normal operation
    EODC_WAIT_NOP = 2'b10    // Soft reset armed, waiting for no-op
  } eodc_reset_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } eodc_apb_req_t;

  typedef struct packed {
    logic             sel_devctl;
    logic             sel_eoc;
    logic             sel_status;
    logic             sel_nop;
    logic             unmapped;
  } eodc_decode_t;

  typedef struct packed {
    logic [NUM_ELEC-1:0] ac_phase;       // 1 = inverted drive
    logic [NUM_ELEC-1:0] ac_enable;      // Effective per-electrode ac detect
    logic [1:0]          ac_level;       // ac_drive_current_level
    logic [2:0]          dc_level;       // Effective dc_drive_current_level
    logic                dc_active;      // dc detection in force
  } eodc_lead_off_cfg_t;

endpackage

// File: eodc_apb_decode.sv
`timescale 1ns/1ns
`default_nettype none

module eodc_apb_decode
(
  input  wire eodc_pkg::eodc_apb_req_t req,
  output eodc_pkg::eodc_decode_t       dec
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Full address compare: aliases would let a stray write hit control
  always_comb
  begin
    dec            = '0;
    dec.sel_devctl = (req.paddr == eodc_pkg::OFS_DEVICE_CONTROL);
    dec.sel_eoc    = (req.paddr == eodc_pkg::OFS_ELECTRODE_OFF_CONTROL);
    dec.sel_status = (req.paddr == eodc_pkg::OFS_DETECT_STATUS);
    dec.sel_nop    = (req.paddr == eodc_pkg::OFS_NO_OPERATION);
    // Anything else answers with an error
    dec.unmapped   = ~(dec.sel_devctl | dec.sel_eoc | dec.sel_status | dec.sel_nop);
  end

endmodule
`default_nettype wire

// File: eodc_electrode_gate.sv
`timescale 1ns/1ns
`default_nettype none

module eodc_electrode_gate
(
  input  wire logic [eodc_pkg::NUM_ELEC-1:0] indiv_enable,
  input  wire logic                          global_select,
  input  wire logic                          detect_enable,
  input  wire logic                          cal_dac_enable,
  output logic      [eodc_pkg::NUM_ELEC-1:0] ac_enable
);

  // ----------------------------------------------------------------
  // Per-electrode ac enable
  // ----------------------------------------------------------------
  // Select is don't-care with detection off; calibration DAC kills ac
  genvar i;
  generate
    for (i = 0; i < eodc_pkg::NUM_ELEC; i++)
    begin : g_elec
      assign ac_enable[i] = detect_enable & ~cal_dac_enable &
                            (indiv_enable[i] |
                             (global_select & eodc_pkg::GLOBAL_AC_MASK[i]));
    end
  endgenerate

endmodule
`default_nettype wire

// File: eodc_electrode_off_detect_control.sv
// How it works
// - Soft reset returns every register to default.
// - Soft reset request bit clears by itself.
// - Phase bits 23:18 select normal or inverted drive.
// - Bits 17:12 are per-electrode ac enables.
// - Effective ac enable is select OR individual.
// - Bits 8:7 pick ac drive current level.
// - Bits 4:2 pick dc current, 10 nA steps.
// - dc current applies only with select clear.
// - Global select covers all but common electrode.
// - Select high swaps dc detection for ac.
// - Select ignored while detection is disabled.
// - Calibration DAC forces all ac detection off.
// - Bit 0 enables detection, resets to off.
`timescale 1ns/1ns
`default_nettype none

module eodc_electrode_off_detect_control
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [eodc_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [eodc_pkg::DATA_W-1:0]      pwdata,
  input  wire logic [eodc_pkg::STRB_W-1:0]      pstrb,
  output logic      [eodc_pkg::DATA_W-1:0]      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  output eodc_pkg::eodc_lead_off_cfg_t          lead_off_cfg
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  // Every flip-flop of the block lives in this one record
  typedef struct packed {
    eodc_pkg::eodc_reset_state_t     rst_state;  // Soft reset sequencer
    logic                            cal_dac;    // Calibration DAC enable
    logic [eodc_pkg::CTRL_W-1:0]     eoc;        // electrode_off_control
    logic [eodc_pkg::DATA_W-1:0]     rdata;      // Read data for access phase
    logic                            rerr;       // Error for access phase
    eodc_pkg::eodc_lead_off_cfg_t    cfg;        // Registered block outputs
  } eodc_main_state_t;

  eodc_main_state_t state_reg;   // Current state
  eodc_main_state_t state_next;  // Next state

  // ----------------------------------------------------------------
  // Bus request bundle and decode
  // ----------------------------------------------------------------
  eodc_pkg::eodc_apb_req_t req;      // Request fields held by the master
  eodc_pkg::eodc_decode_t  dec;      // Register selects
  logic                    setup;    // First cycle of a transfer
  logic                    access;   // Transfer completes this edge
  logic                    wr_take;  // Write takes effect this edge

  assign req.paddr  = paddr;
  assign req.pwrite = pwrite;
  assign req.pwdata = pwdata;
  assign req.pstrb  = pstrb;

  eodc_apb_decode u_decode
  (
    .req (req),
    .dec (dec)
  );

  // Zero wait states: every access phase completes at once
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr_take = access & pwrite;

  // ----------------------------------------------------------------
  // Field views of the control word
  // ----------------------------------------------------------------
  logic [eodc_pkg::NUM_ELEC-1:0] ac_phase;      // Phase per electrode
  logic [eodc_pkg::NUM_ELEC-1:0] indiv_enable;  // Individual ac enables
  logic [1:0]                    ac_level;      // ac current code
  logic [2:0]                    dc_level;      // dc current code
  logic                          global_sel;    // Global ac select
  logic                          detect_en;     // Detection enable
  logic [eodc_pkg::NUM_ELEC-1:0] ac_enable;     // Effective ac enables
  logic                          dc_active;     // dc detection in force

  assign ac_phase     = state_reg.eoc[eodc_pkg::PHASE_MSB:eodc_pkg::PHASE_LSB];
  assign indiv_enable = state_reg.eoc[eodc_pkg::ACEN_MSB:eodc_pkg::ACEN_LSB];
  assign ac_level     = state_reg.eoc[eodc_pkg::ACCUR_MSB:eodc_pkg::ACCUR_LSB];
  assign dc_level     = state_reg.eoc[eodc_pkg::DCCUR_MSB:eodc_pkg::DCCUR_LSB];
  assign global_sel   = state_reg.eoc[eodc_pkg::GLOBAL_AC_DETECT_SELECT_BIT];
  assign detect_en    = state_reg.eoc[eodc_pkg::ELECTRODE_OFF_DETECT_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Effective enables per electrode
  // ----------------------------------------------------------------
  eodc_electrode_gate u_gate
  (
    .indiv_enable   (indiv_enable),
    .global_select  (global_sel),
    .detect_enable  (detect_en),
    .cal_dac_enable (state_reg.cal_dac),
    .ac_enable      (ac_enable)
  );

  // dc detection runs only with detection on and ac mode off
  assign dc_active = detect_en & ~global_sel;

  // ----------------------------------------------------------------
  // Write merge helper
  // ----------------------------------------------------------------
  // Byte strobes pick lanes; reserved bits are forced back to zero
  function automatic logic [eodc_pkg::CTRL_W-1:0] merge_eoc
  (
    input logic [eodc_pkg::CTRL_W-1:0] old_val,
    input logic [eodc_pkg::DATA_W-1:0] wdata,
    input logic [eodc_pkg::STRB_W-1:0] strb
  );
    logic [eodc_pkg::CTRL_W-1:0] val;
    val = old_val;
    for (int b = 0; b < 3; b++)
    begin
      if (strb[b])
      begin
        val[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return val & eodc_pkg::EOC_WRITE_MASK;
  endfunction

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // Captured in the setup cycle so prdata leaves a flip-flop
  logic [eodc_pkg::DATA_W-1:0] rd_mux;       // Selected read word
  logic                        soft_pending; // Soft reset armed

  assign soft_pending = (state_reg.rst_state == eodc_pkg::EODC_WAIT_NOP);

  always_comb
  begin
    rd_mux = '0;
    if (dec.sel_devctl)
    begin
      // Request bit reads 1 only while the sequence is armed
      rd_mux[eodc_pkg::SOFT_RESET_BIT] = soft_pending;
      rd_mux[eodc_pkg::CAL_DAC_BIT]    = state_reg.cal_dac;
    end
    else if (dec.sel_eoc)
    begin
      // Upper eight bits and reserved fields read zero
      rd_mux[eodc_pkg::CTRL_W-1:0] = state_reg.eoc & eodc_pkg::EOC_WRITE_MASK;
    end
    else if (dec.sel_status)
    begin
      // Live view of what the analog side is told
      rd_mux[eodc_pkg::STAT_ACEN_LSB +: eodc_pkg::NUM_ELEC] = state_reg.cfg.ac_enable;
      rd_mux[eodc_pkg::STAT_DC_BIT]                         = state_reg.cfg.dc_active;
      rd_mux[eodc_pkg::STAT_PEND_BIT]                       = soft_pending;
    end
    else
    begin
      // No-op and unmapped offsets read zero
      rd_mux = '0;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // Read word and error flag latched at setup, shown in access
    if (setup)
    begin
      state_next.rdata = pwrite ? '0 : rd_mux;
      state_next.rerr  = dec.unmapped | (pwrite & dec.sel_status);
    end

    // Register writes, taken only at the completing edge
    if (wr_take)
    begin
      if (dec.sel_eoc)
      begin
        state_next.eoc = merge_eoc(state_reg.eoc, pwdata, pstrb);
      end
      if (dec.sel_devctl && pstrb[0])
      begin
        state_next.cal_dac = pwdata[eodc_pkg::CAL_DAC_BIT];
      end
    end

    // Soft reset sequencer
    unique case (state_reg.rst_state)
      eodc_pkg::EODC_RUN:
      begin
        // Writing 1 arms the reset; the bit is never stored as 1
        if (wr_take && dec.sel_devctl && pstrb[0] && pwdata[eodc_pkg::SOFT_RESET_BIT])
        begin
          state_next.rst_state = eodc_pkg::EODC_WAIT_NOP;
        end
      end
      eodc_pkg::EODC_WAIT_NOP:
      begin
        // The no-op write completes the reset and drops the request
        if (wr_take && dec.sel_nop)
        begin
          state_next.rst_state = eodc_pkg::EODC_RUN;
          state_next.eoc       = eodc_pkg::EOC_RESET;
          state_next.cal_dac   = 1'b0;
        end
      end
      default:
      begin
        // Illegal code recovers to normal operation
        state_next.rst_state = eodc_pkg::EODC_RUN;
      end
    endcase

    // Outputs follow the stored fields one edge later
    state_next.cfg.ac_phase  = ac_phase;
    state_next.cfg.ac_enable = ac_enable;
    state_next.cfg.ac_level  = ac_level;
    state_next.cfg.dc_active = dc_active;
    // dc code held at zero drive whenever ac mode owns the inputs
    state_next.cfg.dc_level  = dc_active ? dc_level : 3'h0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg.rst_state <= eodc_pkg::EODC_RUN;
      state_reg.cal_dac   <= 1'b0;
      state_reg.eoc       <= eodc_pkg::EOC_RESET;
      state_reg.rdata     <= 32'h00000000;
      state_reg.rerr      <= 1'b0;
      state_reg.cfg       <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  // pready is a handshake term; data and error come from flip-flops
  assign pready       = access;
  assign prdata       = state_reg.rdata;
  assign pslverr      = access & state_reg.rerr;
  assign lead_off_cfg = state_reg.cfg;

endmodule
`default_nettype wire

// File: eodc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the electrode-off control registers
// ----------------------------------------------------------------
module eodc_asserts
(
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [eodc_pkg::ADDR_W-1:0]  paddr,
  input wire logic [eodc_pkg::DATA_W-1:0]  pwdata,
  input wire logic [eodc_pkg::STRB_W-1:0]  pstrb,
  input wire logic [eodc_pkg::DATA_W-1:0]  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire eodc_pkg::eodc_lead_off_cfg_t lead_off_cfg
);
  logic acc;       // Access phase of any transfer
  logic armed_reg; // Soft reset armed, seen from bus traffic only
  assign acc = psel && penable;
  // Follow the arm and the completing no-op without looking inside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_reg <= 1'b0;
    else if (acc && pwrite && paddr == eodc_pkg::OFS_NO_OPERATION)
      armed_reg <= 1'b0;
    else if (acc && pwrite && paddr == eodc_pkg::OFS_DEVICE_CONTROL
             && pstrb[0] && pwdata[0])
      armed_reg <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Full-word write of the control word; outputs settle two edges on
  sequence eoc_write;
    acc && pwrite && paddr == eodc_pkg::OFS_ELECTRODE_OFF_CONTROL && pstrb == 4'hf;
  endsequence
  sequence nop_while_armed;
    armed_reg && acc && pwrite && paddr == eodc_pkg::OFS_NO_OPERATION;
  endsequence
  ready_zero_wait_a: assert property (acc |-> pready)
    else $error("pready missing in access phase");
  phase_follows_a: assert property (
    eoc_write |-> ##2 lead_off_cfg.ac_phase == $past(pwdata[23:18], 2))
    else $error("ac phase output wrong");
  ac_level_follows_a: assert property (
    eoc_write |-> ##2 lead_off_cfg.ac_level == $past(pwdata[8:7], 2))
    else $error("ac level output wrong");
  dc_level_gate_a: assert property (
    eoc_write |-> ##2 lead_off_cfg.dc_level ==
      (($past(pwdata[1:0], 2) == 2'b01) ? $past(pwdata[4:2], 2) : 3'h0))
    else $error("dc level output wrong");
  detect_off_quiet_a: assert property (
    eoc_write and !pwdata[0] |->
      ##2 (lead_off_cfg.ac_enable == 6'h00 && !lead_off_cfg.dc_active))
    else $error("detection active while disabled");
  common_not_global_a: assert property (
    eoc_write and pwdata[1:0] == 2'b11 && !pwdata[12] |->
      ##2 (!lead_off_cfg.ac_enable[0] && !lead_off_cfg.dc_active))
    else $error("common electrode or dc wrong in ac mode");
  dc_mode_active_a: assert property (
    eoc_write and pwdata[1:0] == 2'b01 |->
      ##2 (lead_off_cfg.dc_active &&
           (lead_off_cfg.ac_enable & ~$past(pwdata[17:12], 2)) == 6'h00))
    else $error("dc mode outputs wrong");
  reserved_zero_a: assert property (
    acc && !pwrite && paddr == eodc_pkg::OFS_ELECTRODE_OFF_CONTROL |->
      prdata[31:24] == 8'h00 && prdata[11:9] == 3'h0 && prdata[6:5] == 2'h0)
    else $error("reserved bits read nonzero");
  reset_req_reads_a: assert property (
    acc && !pwrite && paddr == eodc_pkg::OFS_DEVICE_CONTROL |-> prdata[0] == armed_reg)
    else $error("soft reset request readback wrong");
  soft_reset_clear_a: assert property (nop_while_armed |-> ##2 lead_off_cfg == 18'h00000)
    else $error("soft reset left outputs set");
  unmapped_error_a: assert property (acc && paddr > eodc_pkg::OFS_NO_OPERATION |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule
bind eodc_electrode_off_detect_control eodc_asserts u_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lead_off_cfg(lead_off_cfg));
`default_nettype wire

// File: test_electrode_off_detect_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_electrode_off_detect_control;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic                         pclk;
  logic                         presetn;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [3:0]                   pstrb;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  eodc_pkg::eodc_lead_off_cfg_t cfg;
  logic [31:0]                  rd;        // Read data of the last transfer
  logic                         err;       // Error response of the last transfer
  int                           fail_count = 0;
  int                           n_compared = 0;
  eodc_electrode_off_detect_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lead_off_cfg(cfg));
  // Free-running bus clock, 8 ns period
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; waits for pready with a bound, never a fixed count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs follow one edge after the register changes
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00000000);
    apb(1'b0, eodc_pkg::OFS_DEVICE_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00000000);
    check({14'h0, cfg}, 32'h00000000);
  endtask
  // All ones: reserved bits must stay clear, partial strobe touches lane 0 only
  task automatic t_fields();
    apb(1'b1, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'hffffffff, 4'hf);
    settle();
    check({14'h0, cfg}, {14'h0, 6'h3f, 6'h3f, 2'h3, 3'h0, 1'b0});
    apb(1'b0, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00fff19f);
    apb(1'b1, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h00000000, 4'h1);
    apb(1'b0, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00fff100);
  endtask
  // Walk every current code and every electrode in dc mode
  task automatic t_levels();
    logic [5:0] ph;
    logic [5:0] en;
    for (int i = 0; i < 8; i++)
    begin
      ph = 6'h01 << i;
      en = 6'h20 >> i;
      apb(1'b1, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL,
          {8'h0, ph, en, 3'h0, i[1:0], 2'h0, i[2:0], 2'b01}, 4'hf);
      settle();
      check({14'h0, cfg}, {14'h0, ph, en, i[1:0], i[2:0], 1'b1});
    end
  endtask
  // Enable and select combinations against effective enables and dc path
  task automatic t_modes();
    logic [1:0] md[4] = '{2'b10, 2'b11, 2'b11, 2'b01};
    logic [5:0] ie[4] = '{6'h3f, 6'h00, 6'h01, 6'h01};
    logic [5:0] ea[4] = '{6'h00, 6'h3e, 6'h3f, 6'h01};
    logic [2:0] ed[4] = '{3'h0, 3'h0, 3'h0, 3'h5};
    logic       et[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, {14'h0, ie[i], 7'h0, 3'h5, md[i]}, 4'hf);
      settle();
      check({22'h0, cfg.ac_enable, cfg.dc_level, cfg.dc_active},
            {22'h0, ea[i], ed[i], et[i]});
    end
  endtask
  // Calibration DAC on forces ac detection off, off gives it back
  task automatic t_caldac();
    apb(1'b1, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h0003f003, 4'hf);
    apb(1'b1, eodc_pkg::OFS_DEVICE_CONTROL, 32'h00000002, 4'h1);
    settle();
    check({26'h0, cfg.ac_enable}, 32'h00000000);
    apb(1'b1, eodc_pkg::OFS_DEVICE_CONTROL, 32'h00000000, 4'h1);
    settle();
    check({26'h0, cfg.ac_enable}, 32'h0000003f);
  endtask
  // Arm, confirm nothing clears yet, then complete with the no-op
  task automatic t_soft();
    apb(1'b1, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h00000005, 4'hf);
    apb(1'b1, eodc_pkg::OFS_DEVICE_CONTROL, 32'h00000003, 4'h1);
    apb(1'b0, eodc_pkg::OFS_DEVICE_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00000003);
    apb(1'b0, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00000005);
    apb(1'b1, eodc_pkg::OFS_NO_OPERATION, 32'h00000000, 4'hf);
    apb(1'b0, eodc_pkg::OFS_ELECTRODE_OFF_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00000000);
    apb(1'b0, eodc_pkg::OFS_DEVICE_CONTROL, 32'h0, 4'h0);
    check(rd, 32'h00000000);
    check({14'h0, cfg}, 32'h00000000);
  endtask
  // Unmapped read and write to the read-only status word are refused
  task automatic t_errors();
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    check({rd[30:0], err}, 32'h00000001);
    apb(1'b1, eodc_pkg::OFS_DETECT_STATUS, 32'hffffffff, 4'hf);
    check({31'h0, err}, 32'h00000001);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_levels();
    t_modes();
    t_caldac();
    t_soft();
    t_errors();
    finish_test();
  end
  // A hang costs a mismatch and ends the run the normal way
  initial
  begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
